// [serial_link_startup_sequencer_tb.sv]
// Purpose: end-to-end bench for the converter and receiver link ends
// Assumes: calibration shortened to 4 cycles, one 40 MHz clock
// Notes: driver queues expected rx words, a monitor pops and compares
`timescale 1ns/1ps
module serial_link_startup_sequencer_tb import sls_pkg::*;;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_enable_bit = 1'b0;
  logic scrambler_enable = 1'b0;
  logic double_rate = 1'b0;
  logic software_calibration_trigger = 1'b0;
  logic rx_enable = 1'b0;
  logic sysref_request = 1'b0;
  logic [2:0] decimation = 3'h0;
  logic [4:0] frames_per_multiframe_minus_one = 5'h1f;
  logic [11:0] adc_sample = 12'h800;
  logic [11:0] raw_sample = 12'h800;
  logic [1:0] ph_tb = 2'h0;
  logic tone = 1'b0;
  logic cal_busy, link_up, rx_valid, link_ready;
  logic [31:0] rx_data;
  logic [31:0] exp_q[$];
  logic [2:0] dec_t[6] = '{SLS_DEC_1, SLS_DEC_4, SLS_DEC_8, SLS_DEC_16, SLS_DEC_32, SLS_DEC_1};
  logic [4:0] km1_t[6] = '{5'h1f, 5'h0, 5'h3, 5'h7, 5'h1, 5'h2};
  int num_errors = 0;
  int compares = 0;
  int seed = 32'habf3;

  // free-running 25 ns clock
  always #12.5 clk_i = ~clk_i;

  // mirror of the mixer phase, which counts clocks from reset release
  always @(posedge clk_i) begin
    ph_tb <= reset_i ? 2'h0 : ph_tb + 2'h1;
  end

  // a dc input vanishes in the fs/4 mixer, so ddc runs get a 256 tone on i
  always @(negedge clk_i) begin
    if (!tone) begin
      adc_sample = raw_sample;
    end else begin
      adc_sample = (ph_tb == 2'h0) ? 12'h900 : (ph_tb == 2'h2) ? 12'h700 : 12'h800;
    end
  end

  sls_link_if u_sls_link_if ();
  sls_tx_end #(.CAL_CYCLES(4)) u_sls_tx_end (.clk_i(clk_i), .reset_i(reset_i),
    .link(u_sls_link_if.tx), .link_enable_bit_i(link_enable_bit),
    .decimation_i(decimation), .scrambler_enable_i(scrambler_enable),
    .frames_per_multiframe_minus_one_i(frames_per_multiframe_minus_one),
    .double_rate_i(double_rate), .software_calibration_trigger_i(software_calibration_trigger),
    .adc_sample_i(adc_sample), .cal_busy_o(cal_busy), .link_up_o(link_up));
  sls_rx_end u_sls_rx_end (.clk_i(clk_i), .reset_i(reset_i), .link(u_sls_link_if.rx),
    .rx_enable_i(rx_enable), .sysref_request_i(sysref_request),
    .scrambler_enable_i(scrambler_enable), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .link_ready_o(link_ready));
  sls_link_sva u_sls_link_sva (.clk_i(clk_i), .reset_i(reset_i),
    .sysref(u_sls_link_if.sysref), .sync_n(u_sls_link_if.sync_n),
    .lane_data(u_sls_link_if.lane_data), .lane_ctrl(u_sls_link_if.lane_ctrl),
    .lane_valid(u_sls_link_if.lane_valid));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // full restart; rx drops first so sync_n never rises with tx off
  task automatic bring_up(input logic [2:0] dec, input logic s, input logic d,
      input logic [4:0] km1, input logic sr);
    int n;
    @(negedge clk_i);
    rx_enable = 1'b0;
    @(negedge clk_i);
    link_enable_bit = 1'b0;
    repeat (2) @(negedge clk_i);
    check("link_up off", {31'h0, link_up}, 32'h0);
    decimation = dec;
    scrambler_enable = s;
    double_rate = d;
    frames_per_multiframe_minus_one = km1;
    software_calibration_trigger = 1'b1;
    @(negedge clk_i);
    software_calibration_trigger = 1'b0;
    link_enable_bit = 1'b1; // early enable must wait for calibration
    n = 0;
    while (cal_busy === 1'b1 && n < 100) begin
      check("link_up in cal", {31'h0, link_up}, 32'h0);
      n++;
      @(negedge clk_i);
    end
    check("cal cycles", 32'(n), 32'h4);
    if (sr) begin
      sysref_request = 1'b1;
      @(negedge clk_i);
      sysref_request = 1'b0;
    end
    rx_enable = 1'b1;
    n = 0;
    while (!(link_up === 1'b1 && link_ready === 1'b1) && n < 2000) begin
      n++;
      @(negedge clk_i);
    end
    check("link_up on", {31'h0, link_up}, 32'h1);
    check("link_ready on", {31'h0, link_ready}, 32'h1);
  endtask

  // settle past in-flight frames, then note one expected word
  task automatic expect_word(input logic [31:0] w);
    int n;
    n = 0;
    repeat (20) @(negedge clk_i);
    exp_q.push_back(w);
    while (exp_q.size() > 0 && n < 40) begin
      n++;
      @(negedge clk_i);
    end
    check("rx words pending", 32'(exp_q.size()), 32'h0);
    exp_q.delete();
  endtask

  // ----------------------------------------------------------------
  // monitor and main sequence
  // ----------------------------------------------------------------
  // oldest note against each received word
  always @(negedge clk_i) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) begin
      check("rx_data", rx_data, exp_q.pop_front());
    end
  end

  // configurations cover every decimation code, ddr, scrambler, sysref
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    check("sync_n idle", {31'h0, u_sls_link_if.sync_n}, 32'h1);
    check("cal_busy idle", {31'h0, cal_busy}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      raw_sample = 12'h800;
      tone = (dec_t[i] != SLS_DEC_1);
      bring_up(dec_t[i], i[0], i[1], km1_t[i], !i[0]);
      if (dec_t[i] == SLS_DEC_1) begin
        for (int j = 0; j < 3; j++) begin
          raw_sample = 12'($random(seed));
          expect_word({20'h0, raw_sample});
        end
        decimation = SLS_DEC_4; // ignored while the link runs
        software_calibration_trigger = 1'b1;
        @(negedge clk_i);
        software_calibration_trigger = 1'b0;
        @(negedge clk_i);
        check("cal while on", {31'h0, cal_busy}, 32'h0);
        raw_sample = 12'($random(seed));
        expect_word({20'h0, raw_sample});
      end else begin
        // half the samples carry 256 on i; sum of d scaled to 15 bits gives 1024
        expect_word(32'h04000000);
      end
      $display("test %0d done", i);
    end
    link_enable_bit = 1'b0;
    repeat (3) @(negedge clk_i);
    check("link_up after off", {31'h0, link_up}, 32'h0);
    $display("test disable done");
    wrap_up();
  end

  // hang guard: six bring-ups take far fewer than 20000 cycles
  initial begin
    #500000;
    num_errors++;
    wrap_up();
  end
endmodule // serial_link_startup_sequencer_tb

// [sls_link_if.sv]
// Purpose: link wires between the transmitting converter and its receiver
// Assumes: both ends on the same clock, supplied by the testbench
// Notes: sync_n is active low, sysref is a rising-edge event
`timescale 1ns/1ps
interface sls_link_if;
  logic sysref;
  logic sync_n;
  logic [31:0] lane_data;
  logic [3:0] lane_ctrl;
  logic lane_valid;

  modport tx (input sysref, input sync_n, output lane_data, output lane_ctrl,
    output lane_valid);
  modport rx (output sysref, output sync_n, input lane_data, input lane_ctrl,
    input lane_valid);
endinterface

// [sls_link_sva.sv]
// Purpose: watches the link wires between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes: sees only interface signals, so no config-dependent checks
`timescale 1ns/1ps
module sls_link_sva
  import sls_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sysref,
  input wire logic sync_n,
  input wire logic [31:0] lane_data,
  input wire logic [3:0] lane_ctrl,
  input wire logic lane_valid
);
  // ----------------------------------------------------------------
  // frame decode and helper counters
  // ----------------------------------------------------------------
  logic k_cgs, k_end, k_mark, data_frame, last_end;
  logic mark_seen_q, mark_seen_d;
  logic [2:0] k_cnt_q, k_cnt_d, end_cnt_q, end_cnt_d;

  // classify each lane word by its control byte
  assign k_cgs = lane_valid && lane_ctrl[0] && (lane_data[7:0] == SLS_K_CGS);
  assign k_end = lane_valid && lane_ctrl[0] && (lane_data[7:0] == SLS_K_ILA_END);
  assign k_mark = k_end || (lane_valid && lane_ctrl[0] && (lane_data[7:0] == SLS_K_ILA_START));
  assign data_frame = lane_valid && (lane_ctrl == 4'h0);
  assign last_end = k_end && (end_cnt_q == 3'h3);

  // run of sync chars while requested; ila end marks since the request
  always_comb begin
    k_cnt_d = k_cnt_q;
    end_cnt_d = end_cnt_q;
    if (sync_n) begin
      k_cnt_d = 3'h0;
    end else if (lane_valid) begin
      k_cnt_d = !k_cgs ? 3'h0 : (k_cnt_q == 3'h7) ? k_cnt_q : k_cnt_q + 3'h1;
    end
    // any ila mark since the last sync request; a bounded stand-in for until
    mark_seen_d = !sync_n ? 1'b0 : (mark_seen_q || k_mark);
    if (!sync_n) begin
      end_cnt_d = 3'h0;
    end else if (k_end && end_cnt_q != 3'h7) begin
      end_cnt_d = end_cnt_q + 3'h1;
    end
  end

  // registers only; saturating so a long run never wraps back to zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      k_cnt_q <= 3'h0;
      end_cnt_q <= 3'h0;
      mark_seen_q <= 1'b0;
    end else begin
      k_cnt_q <= k_cnt_d;
      end_cnt_q <= end_cnt_d;
      mark_seen_q <= mark_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a reset in mid-request also raises sync_n, which is not a release
  sequence sync_release;
    $rose(sync_n) && !$past(reset_i);
  endsequence
  sequence ila_begins;
    ##[1:200] k_mark;
  endsequence
  sequence data_no_gap;
    data_frame or (!lane_valid ##1 data_frame);
  endsequence

  AST_ILA_FOLLOWS_CGS: assert property (sync_release |-> ila_begins)
    else $error("no ila mark after sync release");
  AST_NO_DATA_BEFORE_ILA: assert property ((sync_n && data_frame) |-> mark_seen_q)
    else $error("data frame before ila");
  AST_SYNC_AFTER_FOUR_K: assert property (sync_release |-> k_cnt_q >= SLS_CGS_COUNT)
    else $error("sync released before four sync chars");
  AST_SYNC_HELD: assert property (sync_release |-> sync_n [*8])
    else $error("sync dropped during alignment");
  AST_CGS_CHARS: assert property ((!sync_n && !$past(sync_n, 3) && lane_valid) |-> k_cgs)
    else $error("non sync char while sync requested");
  AST_DATA_AFTER_ILA: assert property (last_end |=> data_no_gap)
    else $error("gap or control after last ila frame");
  AST_FOUR_ILA_ENDS: assert property (k_end |-> end_cnt_q < SLS_ILA_MULTIFRAMES)
    else $error("more ila end marks than multiframes");
  AST_CTRL_ONE_BYTE: assert property (lane_ctrl[3:1] == 3'h0)
    else $error("control flag outside byte 0");
endmodule // sls_link_sva

// [sls_pkg.sv]
// Purpose: shared constants and types for the serial link startup sequencer
// Assumes: one frame per lane word, 32-bit lane words, one clock for both ends
// Notes: control characters follow the usual 8b/10b K-code byte values
package sls_pkg;

  // ----------------------------------------------------------------
  // control characters carried in byte 0 of a lane word
  // ----------------------------------------------------------------
  localparam logic [7:0] SLS_K_CGS = 8'hbc;
  localparam logic [7:0] SLS_K_ILA_START = 8'h1c;
  localparam logic [7:0] SLS_K_ILA_END = 8'h7c;

  // ----------------------------------------------------------------
  // sequence counts and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SLS_ILA_MULTIFRAMES = 3'h4;
  localparam logic [2:0] SLS_CGS_COUNT = 3'h4;
  localparam int SLS_CLK_PERIOD_NS = 25;
  localparam int SLS_CAL_TIME_NS = 10000;
  localparam int SLS_CAL_CYCLES = (SLS_CAL_TIME_NS + SLS_CLK_PERIOD_NS - 1) / SLS_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // reset values of the configuration shadow
  // ----------------------------------------------------------------
  localparam logic [4:0] SLS_KM1_RST = 5'h1f;
  localparam logic [2:0] SLS_DEC_RST = 3'h0;

  // decimation select codes: 0 bypass, then 4, 8, 16, 32
  typedef enum logic [2:0] {
    SLS_DEC_1 = 3'h0,
    SLS_DEC_4 = 3'h1,
    SLS_DEC_8 = 3'h2,
    SLS_DEC_16 = 3'h3,
    SLS_DEC_32 = 3'h4
  } sls_dec_t;

  typedef enum logic [2:0] {
    TX_OFF, TX_WAIT_SYNC, TX_CGS, TX_ILA_WAIT, TX_ILA, TX_DATA
  } sls_tx_state_t;

  typedef enum logic [1:0] {
    RX_OFF, RX_CGS, RX_ILA, RX_DATA
  } sls_rx_state_t;

endpackage

// [sls_rx_end.sv]
// Purpose: receiver side of the link: sysref, sync request, cgs, ila, data capture
// Assumes: lane signals come from logic on the same clock
// Notes: descrambler must match the transmitter setting
`timescale 1ns/1ps
module sls_rx_end
  import sls_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  sls_link_if.rx link,
  input wire logic rx_enable_i,
  input wire logic sysref_request_i,
  input wire logic scrambler_enable_i,
  output logic [31:0] rx_data_o,
  output logic rx_valid_o,
  output logic link_ready_o
);

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  sls_rx_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [14:0] dscr_q, dscr_d;
  logic [31:0] data_q, data_d, plain;
  logic valid_q, valid_d, sysref_q, syncn_q, syncn_d;
  logic [14:0] s;
  logic is_k, is_a;

  assign is_k = link.lane_ctrl[0] && link.lane_data[7:0] == SLS_K_CGS;
  assign is_a = link.lane_ctrl[0] && link.lane_data[7:0] == SLS_K_ILA_END;

  // self-synchronous descrambler: state shifts in received bits
  always_comb begin
    s = dscr_q;
    plain = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      plain[i] = link.lane_data[i] ^ s[14] ^ s[13];
      s = {s[13:0], link.lane_data[i]};
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    dscr_d = dscr_q;
    data_d = data_q;
    valid_d = 1'b0;
    case (state_q)
      RX_OFF: begin
        cnt_d = 3'h0;
        if (rx_enable_i) begin
          state_d = RX_CGS;
        end
      end
      RX_CGS: begin
        if (link.lane_valid) begin
          cnt_d = is_k ? cnt_q + 3'h1 : 3'h0;
          if (is_k && cnt_q == SLS_CGS_COUNT - 3'h1) begin
            state_d = RX_ILA;
            cnt_d = 3'h0;
          end
        end
      end
      RX_ILA: begin
        if (link.lane_valid && is_a) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == SLS_ILA_MULTIFRAMES - 3'h1) begin
            state_d = RX_DATA;
          end
        end
      end
      default: begin
        if (link.lane_valid) begin
          valid_d = 1'b1;
          data_d = scrambler_enable_i ? plain : link.lane_data;
          dscr_d = s;
        end
      end
    endcase
    if (!rx_enable_i) begin
      state_d = RX_OFF;
    end
    syncn_d = !(state_d == RX_CGS);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= RX_OFF;
      cnt_q <= 3'h0;
      dscr_q <= 15'h7fff;
      data_q <= 32'h00000000;
      valid_q <= 1'b0;
      syncn_q <= 1'b1;
      sysref_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dscr_q <= dscr_d;
      data_q <= data_d;
      valid_q <= valid_d;
      syncn_q <= syncn_d;
      sysref_q <= sysref_request_i;
    end
  end

  assign link.sysref = sysref_q;
  assign link.sync_n = syncn_q;
  assign rx_data_o = data_q;
  assign rx_valid_o = valid_q;
  assign link_ready_o = (state_q == RX_DATA);

endmodule // sls_rx_end

// [sls_tx_end.sv]
// Purpose: converter side of the link: config lock, calibration, lmfc, cgs, ila, data
// Assumes: one converter sample per clock on adc_sample_i, offset binary
// Notes: in TX_DATA the lane carries the latest output sample on every frame tick
`timescale 1ns/1ps

module sls_tx_end
  import sls_pkg::*;
#(
  parameter int CAL_CYCLES = SLS_CAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  sls_link_if.tx link,
  input wire logic link_enable_bit_i,
  input wire logic [2:0] decimation_i,
  input wire logic scrambler_enable_i,
  input wire logic [4:0] frames_per_multiframe_minus_one_i,
  input wire logic double_rate_i,
  input wire logic software_calibration_trigger_i,
  input wire logic [11:0] adc_sample_i,
  output logic cal_busy_o,
  output logic link_up_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sysref_m_q, sysref_s_q, sysref_p_q, syncn_m_q, syncn_s_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sysref_m_q <= 1'b0;
      sysref_s_q <= 1'b0;
      sysref_p_q <= 1'b0;
      syncn_m_q <= 1'b1;
      syncn_s_q <= 1'b1;
    end else begin
      sysref_m_q <= link.sysref;
      sysref_s_q <= sysref_m_q;
      sysref_p_q <= sysref_s_q;
      syncn_m_q <= link.sync_n;
      syncn_s_q <= syncn_m_q;
    end
  end

  logic sysref_edge;
  assign sysref_edge = sysref_s_q & ~sysref_p_q;

  // ----------------------------------------------------------------
  // configuration shadow and calibration
  // ----------------------------------------------------------------
  sls_tx_state_t state_q, state_d;
  logic [2:0] dec_q, dec_d;
  logic scr_en_q, scr_en_d, ddr_q, ddr_d;
  logic [4:0] km1_q, km1_d;
  logic [15:0] cal_q, cal_d;

  // shadow tracks the inputs only while the link is off, so a live link never
  // sees a half-changed setup
  always_comb begin
    dec_d = dec_q;
    scr_en_d = scr_en_q;
    ddr_d = ddr_q;
    km1_d = km1_q;
    cal_d = cal_q;
    if (state_q == TX_OFF) begin
      dec_d = (decimation_i > 3'(SLS_DEC_32)) ? 3'(SLS_DEC_32) : decimation_i;
      scr_en_d = scrambler_enable_i;
      ddr_d = double_rate_i;
      km1_d = frames_per_multiframe_minus_one_i;
    end
    if (cal_q != 16'h0000) begin
      cal_d = cal_q - 16'h0001;
    end else if (software_calibration_trigger_i && state_q == TX_OFF) begin
      cal_d = 16'(CAL_CYCLES);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dec_q <= SLS_DEC_RST;
      scr_en_q <= 1'b0;
      ddr_q <= 1'b0;
      km1_q <= SLS_KM1_RST;
      cal_q <= 16'h0000;
    end else begin
      dec_q <= dec_d;
      scr_en_q <= scr_en_d;
      ddr_q <= ddr_d;
      km1_q <= km1_d;
      cal_q <= cal_d;
    end
  end

  assign cal_busy_o = (cal_q != 16'h0000);

  // ----------------------------------------------------------------
  // frame rate divider and multiframe counter
  // ----------------------------------------------------------------
  logic div_q, div_d, frame_tick, lmfc_wrap;
  logic [4:0] lmfc_q, lmfc_d;

  // normal rate sends a frame every second clock, double rate every clock
  assign frame_tick = ddr_q | div_q;
  assign lmfc_wrap = frame_tick && (lmfc_q == km1_q);

  // counter starts at zero after reset and keeps running without sysref
  always_comb begin
    div_d = ~div_q;
    lmfc_d = lmfc_q;
    if (sysref_edge && state_q != TX_OFF) begin
      lmfc_d = 5'h00;
    end else if (lmfc_wrap) begin
      lmfc_d = 5'h00;
    end else if (frame_tick) begin
      lmfc_d = lmfc_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_q <= 1'b0;
      lmfc_q <= 5'h00;
    end else begin
      div_q <= div_d;
      lmfc_q <= lmfc_d;
    end
  end

  // ----------------------------------------------------------------
  // down-converter: fs/4 mixer and block-sum decimator
  // ----------------------------------------------------------------
  logic [1:0] ph_q;
  logic [4:0] dcnt_q, dcnt_d;
  logic signed [17:0] acc_i_q, acc_i_d, acc_q_q, acc_q_d;
  logic [14:0] out_i_q, out_i_d, out_q_q, out_q_d;
  logic signed [12:0] smp, mix_i, mix_q;
  logic signed [17:0] sum_i, sum_q, sh_i, sh_q;
  logic [4:0] dlast;
  logic [2:0] shamt;

  // flip the msb to turn offset binary into two's complement
  assign smp = 13'(signed'({~adc_sample_i[11], adc_sample_i[10:0]}));
  assign dlast = 5'((6'h02 << dec_q) - 6'h01);
  assign shamt = 3'(3'h4 - dec_q);

  always_comb begin
    mix_i = 13'sh0000;
    mix_q = 13'sh0000;
    case (ph_q)
      2'h0: mix_i = smp;
      2'h1: mix_q = -smp;
      2'h2: mix_i = -smp;
      default: mix_q = smp;
    endcase
    sum_i = acc_i_q + 18'(mix_i);
    sum_q = acc_q_q + 18'(mix_q);
    sh_i = sum_i <<< shamt;
    sh_q = sum_q <<< shamt;
    acc_i_d = sum_i;
    acc_q_d = sum_q;
    out_i_d = out_i_q;
    out_q_d = out_q_q;
    dcnt_d = dcnt_q + 5'h01;
    if (dcnt_q >= dlast) begin
      out_i_d = sh_i[16:2];
      out_q_d = sh_q[16:2];
      acc_i_d = 18'sh00000;
      acc_q_d = 18'sh00000;
      dcnt_d = 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ph_q <= 2'h0;
      dcnt_q <= 5'h00;
      acc_i_q <= 18'sh00000;
      acc_q_q <= 18'sh00000;
      out_i_q <= 15'h0000;
      out_q_q <= 15'h0000;
    end else begin
      ph_q <= ph_q + 2'h1;
      dcnt_q <= dcnt_d;
      acc_i_q <= acc_i_d;
      acc_q_q <= acc_q_d;
      out_i_q <= out_i_d;
      out_q_q <= out_q_d;
    end
  end

  // ----------------------------------------------------------------
  // link sequencer and lane word generation
  // ----------------------------------------------------------------
  logic [2:0] mf_q, mf_d;
  logic [14:0] scr_q, scr_d;
  logic [31:0] data_q, data_d, payload;
  logic [3:0] ctrl_q, ctrl_d;
  logic valid_q, valid_d;
  logic [46:0] scr_out;

  // self-synchronous 1 + x^14 + x^15 scrambler, msb first
  function automatic logic [46:0] scramble(input logic [31:0] d, input logic [14:0] st);
    logic [14:0] s;
    logic [31:0] o;
    s = st;
    o = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      o[i] = d[i] ^ s[14] ^ s[13];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  assign payload = (dec_q == 3'(SLS_DEC_1)) ? {20'h00000, adc_sample_i} :
    {out_i_q[14], out_i_q, out_q_q[14], out_q_q};
  assign scr_out = scramble(payload, scr_q);

  always_comb begin
    state_d = state_q;
    mf_d = mf_q;
    scr_d = scr_q;
    data_d = data_q;
    ctrl_d = ctrl_q;
    valid_d = 1'b0;
    case (state_q)
      TX_OFF: begin
        if (link_enable_bit_i && !cal_busy_o) begin
          state_d = TX_WAIT_SYNC;
        end
      end
      TX_WAIT_SYNC: begin
        if (!syncn_s_q) begin
          state_d = TX_CGS;
        end
      end
      TX_CGS: begin
        if (syncn_s_q) begin
          state_d = TX_ILA_WAIT;
        end
      end
      TX_ILA_WAIT: begin
        if (lmfc_wrap) begin
          state_d = TX_ILA;
          mf_d = 3'h0;
        end
      end
      TX_ILA: begin
        if (lmfc_wrap) begin
          mf_d = mf_q + 3'h1;
          if (mf_q == SLS_ILA_MULTIFRAMES - 3'h1) begin
            state_d = TX_DATA;
          end
        end
      end
      default: ;
    endcase
    // a fresh sync request restarts code group sync from any live state
    if (state_q > TX_CGS && !syncn_s_q) begin
      state_d = TX_CGS;
    end
    if (!link_enable_bit_i) begin
      state_d = TX_OFF;
    end
    // lane word for this frame
    if (frame_tick && state_q != TX_OFF) begin
      valid_d = 1'b1;
      ctrl_d = 4'h1;
      data_d = {24'h000000, SLS_K_CGS};
      if (state_q == TX_ILA) begin
        if (lmfc_q == km1_q) begin
          data_d = {24'h000000, SLS_K_ILA_END};
        end else if (lmfc_q == 5'h00) begin
          data_d = {24'h000000, SLS_K_ILA_START};
        end else begin
          ctrl_d = 4'h0;
          data_d = (mf_q == 3'h1) ? {16'h0000, 4'h0, dec_q, scr_en_q, ddr_q, km1_q, 2'h0} :
            {27'h0, lmfc_q};
        end
      end else if (state_q == TX_DATA) begin
        ctrl_d = 4'h0;
        data_d = scr_en_q ? scr_out[31:0] : payload;
        scr_d = scr_en_q ? scr_out[46:32] : scr_q;
      end
    end else if (state_q == TX_OFF) begin
      ctrl_d = 4'h0;
      data_d = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= TX_OFF;
      mf_q <= 3'h0;
      scr_q <= 15'h7fff;
      data_q <= 32'h00000000;
      ctrl_q <= 4'h0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mf_q <= mf_d;
      scr_q <= scr_d;
      data_q <= data_d;
      ctrl_q <= ctrl_d;
      valid_q <= valid_d;
    end
  end

  assign link.lane_data = data_q;
  assign link.lane_ctrl = ctrl_q;
  assign link.lane_valid = valid_q;
  assign link_up_o = (state_q == TX_DATA);

endmodule // sls_tx_end
